// *** design/pps_pkg.sv ***
// Package: offsets, field positions and reset values of the primary pin and clock status bank
package pps_pkg;

  // ==========================================================================
  // Register map
  localparam logic [6:0] PPS_ADDR_PIN_LEVELS = 7'h0A;
  localparam logic [6:0] PPS_ADDR_CLK_CHECK = 7'h0B;

  // ==========================================================================
  // Pin level register fields
  localparam int PPS_BIT_FAULT_B = 6;
  localparam int PPS_BIT_FAULT_A = 5;
  localparam int PPS_BIT_ENABLE = 4;
  localparam int PPS_BIT_INV_PWM = 3;
  localparam int PPS_BIT_PWM = 2;
  localparam int PPS_RES_HW_HI = 8;
  localparam int PPS_RES_HW_LO = 7;

  // ==========================================================================
  // Fields common to every word
  localparam int PPS_BIT_REJECTED = 1;
  localparam int PPS_BIT_PARITY = 0;

  // ==========================================================================
  // Clock check register fields
  localparam int PPS_CNT_HI = 15;
  localparam int PPS_CNT_LO = 8;
  localparam int PPS_CNT_W = 8;
  localparam logic [7:0] PPS_CNT_RESET = 8'h00;
  localparam logic [7:0] PPS_CNT_MAX = 8'hFF;
  localparam logic [15:0] PPS_CLK_CHECK_RESET = 16'h0001;

  // ==========================================================================
  // Verification function select
  localparam logic [1:0] PPS_VSEL_DISABLED = 2'h0;
  localparam logic [1:0] PPS_VSEL_CLK_CHECK = 2'h2;

  // ==========================================================================
  // Pin synchroniser
  localparam int PPS_SYNC_STAGES = 2;
  localparam int PPS_NUM_PINS = 6;

  typedef enum logic [1:0] {
    PPS_MEAS_IDLE,
    PPS_MEAS_ARMED,
    PPS_MEAS_COUNT
  } pps_meas_state_t;

endpackage : pps_pkg

// *** design/pps_status.sv ***
// Primary pin level and clock check status registers with read port
//
// Function
// - Bit 6 of the pin level word shows the sampled level of fault pin B, 1 for high.
// - Bit 5 of the pin level word shows the sampled level of fault pin A, 1 for high.
// - Bit 4 of the pin level word shows the sampled level of the enable pin, 1 for high.
// - Bit 3 of the pin level word shows the sampled level of the inverted PWM pin.
// - Bits 8:7 of the pin level word are hardware-owned with no meaning to software.
// - Bit 1 of every returned word is 1 when the previous frame was discarded, else 0.
// - Bit 0 of every returned word makes the whole 16-bit word odd parity.
// - Bits 15:8 of the clock check word hold the measured cycle count, read-only.
// - Select value 10 starts a check only on self-test entry; default entry clears it.
module pps_status
  import pps_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Device pins
  input wire logic fault_a_notify_pin,
  input wire logic fault_b_notify_pin,
  input wire logic enable_pin,
  input wire logic inverted_pwm_pin,
  input wire logic pwm_input_pin,
  input wire logic ref_window_pin,
  // Frame logic status
  input wire logic last_frame_rejected,
  // Register read port
  input wire logic rd_en,
  input wire logic [6:0] rd_addr,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic rd_unmapped,
  // Control register and mode events
  input wire logic verification_select_we,
  input wire logic [1:0] verification_select_wdata,
  input wire logic clear_primary_bit,
  input wire logic self_test_entry,
  input wire logic default_mode_entry,
  // Clock check status
  output logic [1:0] verification_select,
  output logic check_active,
  output logic check_done
);

  // ==========================================================================
  // Pin synchronisers
  logic [PPS_NUM_PINS-1:0] pins_s;
  logic fault_a_s;
  logic fault_b_s;
  logic enable_s;
  logic inv_pwm_s;
  logic pwm_s;
  logic window_s;

  pps_sync #(
    .WIDTH(PPS_NUM_PINS)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .async_in({ref_window_pin, pwm_input_pin, inverted_pwm_pin, enable_pin,
               fault_a_notify_pin, fault_b_notify_pin}),
    .sync_out(pins_s)
  );

  assign fault_b_s = pins_s[0];
  assign fault_a_s = pins_s[1];
  assign enable_s = pins_s[2];
  assign inv_pwm_s = pins_s[3];
  assign pwm_s = pins_s[4];
  assign window_s = pins_s[5];

  // ==========================================================================
  // Verification select field
  logic [1:0] verification_select_q;
  logic check_active_q;
  logic check_done_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      verification_select_q <= PPS_VSEL_DISABLED;
    end else if (default_mode_entry) begin
      verification_select_q <= PPS_VSEL_DISABLED;
    end else if (verification_select_we) begin
      verification_select_q <= verification_select_wdata;
    end
  end

  // Selection only acts at self-test entry, so a later write cannot start a check
  always_ff @(posedge clk) begin
    if (srst) begin
      check_active_q <= 1'b0;
    end else if (default_mode_entry || check_done_q) begin
      check_active_q <= 1'b0;
    end else if (self_test_entry) begin
      check_active_q <= (verification_select_q == PPS_VSEL_CLK_CHECK);
    end
  end

  // ==========================================================================
  // Oscillator cycle measurement over one reference window
  pps_meas_state_t meas_state_q;
  logic [PPS_CNT_W-1:0] run_cnt_q;
  logic [PPS_CNT_W-1:0] measured_q;
  logic window_end;

  assign window_end = (meas_state_q == PPS_MEAS_COUNT) && !window_s;

  always_ff @(posedge clk) begin
    if (srst) begin
      meas_state_q <= PPS_MEAS_IDLE;
    end else begin
      case (meas_state_q)
        PPS_MEAS_IDLE: begin
          // Wait for a low so a window already open is not measured short
          if (check_active_q && !window_s) begin
            meas_state_q <= PPS_MEAS_ARMED;
          end
        end
        PPS_MEAS_ARMED: begin
          if (!check_active_q) begin
            meas_state_q <= PPS_MEAS_IDLE;
          end else if (window_s) begin
            meas_state_q <= PPS_MEAS_COUNT;
          end
        end
        PPS_MEAS_COUNT: begin
          if (!check_active_q || !window_s) begin
            meas_state_q <= PPS_MEAS_IDLE;
          end
        end
        default: begin
          meas_state_q <= PPS_MEAS_IDLE;
        end
      endcase
    end
  end

  // Count saturates; an overlong window reads as the maximum
  always_ff @(posedge clk) begin
    if (srst) begin
      run_cnt_q <= PPS_CNT_RESET;
    end else if (meas_state_q != PPS_MEAS_COUNT) begin
      run_cnt_q <= PPS_CNT_RESET;
    end else if (run_cnt_q != PPS_CNT_MAX) begin
      run_cnt_q <= run_cnt_q + 8'h01;
    end
  end

  // A finished measurement wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      measured_q <= PPS_CNT_RESET;
    end else if (window_end && check_active_q) begin
      measured_q <= run_cnt_q;
    end else if (clear_primary_bit) begin
      measured_q <= PPS_CNT_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      check_done_q <= 1'b0;
    end else begin
      check_done_q <= window_end && check_active_q;
    end
  end

  // ==========================================================================
  // Read words
  logic [15:0] pin_word;
  logic [15:0] clk_word;
  logic [15:0] sel_word;
  logic addr_ok;

  always_comb begin
    pin_word = 16'h0000;
    pin_word[PPS_BIT_FAULT_B] = fault_b_s;
    pin_word[PPS_BIT_FAULT_A] = fault_a_s;
    pin_word[PPS_BIT_ENABLE] = enable_s;
    pin_word[PPS_BIT_INV_PWM] = inv_pwm_s;
    pin_word[PPS_BIT_PWM] = pwm_s;
    // Reserved hardware bits carry no state here
    pin_word[PPS_RES_HW_HI:PPS_RES_HW_LO] = 2'h0;
    clk_word = 16'h0000;
    clk_word[PPS_CNT_HI:PPS_CNT_LO] = measured_q;
    addr_ok = 1'b1;
    case (rd_addr)
      PPS_ADDR_PIN_LEVELS: sel_word = pin_word;
      PPS_ADDR_CLK_CHECK: sel_word = clk_word;
      default: begin
        sel_word = 16'h0000;
        addr_ok = 1'b0;
      end
    endcase
    sel_word[PPS_BIT_REJECTED] = last_frame_rejected;
    sel_word[PPS_BIT_PARITY] = ~^sel_word[15:1];
  end

  logic [15:0] rd_data_q;
  logic rd_valid_q;
  logic rd_unmapped_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data_q <= PPS_CLK_CHECK_RESET;
    end else if (rd_en) begin
      rd_data_q <= sel_word;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_valid_q <= 1'b0;
      rd_unmapped_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en;
      rd_unmapped_q <= rd_en && !addr_ok;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign rd_unmapped = rd_unmapped_q;
  assign verification_select = verification_select_q;
  assign check_active = check_active_q;
  assign check_done = check_done_q;

  // ==========================================================================
  // Assertions
  property p_fault_b;
    @(posedge clk) disable iff (srst)
    rd_en && rd_addr == PPS_ADDR_PIN_LEVELS |=> rd_data_q[6] == $past(fault_b_s);
  endproperty
  a_fault_b: assert property (p_fault_b) else $error("fault B level wrong");

  property p_fault_a;
    @(posedge clk) disable iff (srst)
    rd_en && rd_addr == PPS_ADDR_PIN_LEVELS |=> rd_data_q[5] == $past(fault_a_s);
  endproperty
  a_fault_a: assert property (p_fault_a) else $error("fault A level wrong");

  property p_enable;
    @(posedge clk) disable iff (srst)
    rd_en && rd_addr == PPS_ADDR_PIN_LEVELS |=> rd_data_q[4] == $past(enable_s);
  endproperty
  a_enable: assert property (p_enable) else $error("enable level wrong");

  property p_inv_pwm;
    @(posedge clk) disable iff (srst)
    rd_en && rd_addr == PPS_ADDR_PIN_LEVELS |=> rd_data_q[3] == $past(inv_pwm_s);
  endproperty
  a_inv_pwm: assert property (p_inv_pwm) else $error("inverted PWM level wrong");

  property p_rejected;
    @(posedge clk) disable iff (srst)
    rd_en |=> rd_valid_q && rd_data_q[1] == $past(last_frame_rejected);
  endproperty
  a_rejected: assert property (p_rejected) else $error("reject flag wrong");

  property p_parity;
    @(posedge clk) disable iff (srst)
    rd_valid_q |-> ^rd_data_q == 1'b1;
  endproperty
  a_parity: assert property (p_parity) else $error("word parity not odd");

  property p_reserved;
    @(posedge clk) disable iff (srst)
    rd_valid_q |-> (rd_data_q[15:7] == 9'h000 || $past(rd_addr) != PPS_ADDR_PIN_LEVELS)
      && (rd_data_q[7:2] == 6'h00 || $past(rd_addr) != PPS_ADDR_CLK_CHECK);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_count_load;
    @(posedge clk) disable iff (srst)
    window_end && check_active_q |=> measured_q == $past(run_cnt_q) ##1 $fell(check_active_q);
  endproperty
  a_count_load: assert property (p_count_load) else $error("measured count not stored");

  property p_clear;
    @(posedge clk) disable iff (srst)
    clear_primary_bit && !(window_end && check_active_q) |=> measured_q == PPS_CNT_RESET;
  endproperty
  a_clear: assert property (p_clear) else $error("count not cleared");

  property p_sel_entry;
    @(posedge clk) disable iff (srst)
    self_test_entry && !default_mode_entry && !check_done_q
      |=> check_active_q == ($past(verification_select_q) == PPS_VSEL_CLK_CHECK);
  endproperty
  a_sel_entry: assert property (p_sel_entry) else $error("check start wrong");

  property p_default_clear;
    @(posedge clk) disable iff (srst)
    default_mode_entry |=> verification_select_q == PPS_VSEL_DISABLED && !check_active_q;
  endproperty
  a_default_clear: assert property (p_default_clear) else $error("select not cleared");

endmodule : pps_status

// *** design/pps_sync.sv ***
// Two-stage synchroniser, one chain per bit
module pps_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Asynchronous inputs and synchronised levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // Per-bit chains
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic stable_q;
      // First stage feeds only the second stage
      always_ff @(posedge clk) begin
        if (srst) begin
          meta_q <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q <= async_in[i];
          stable_q <= meta_q;
        end
      end
      assign sync_out[i] = stable_q;
    end
  endgenerate

endmodule : pps_sync

// *** tb/pps_host.sv ***
// Controller-side model issuing register reads
module pps_host (
  // Clock
  input wire logic clk,
  // Read port
  output logic rd_en,
  output logic [6:0] rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_unmapped
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rd_en = 1'b0;
    rd_addr = 7'h55;
  end

  // ==========================================================================
  // Read cycle
  // Address scrambled once released, so a stale latch cannot pass
  task automatic read(input logic [6:0] addr, output logic [15:0] data,
      output logic um, output logic vld);
    @(negedge clk);
    rd_en = 1'b1;
    rd_addr = addr;
    @(negedge clk);
    rd_en = 1'b0;
    rd_addr = ~addr;
    vld = rd_valid;
    data = rd_data;
    um = rd_unmapped;
  endtask : read
endmodule : pps_host

// *** tb/tb_top.sv ***
// Self-checking bench for the primary pin and clock status bank
module tb_top import pps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, srst, fa, fb, en, ipwm, pwm, win, lfr, rd_en, rd_valid, rd_unmapped;
  logic vs_we, clr, ste, dme, act, done;
  logic [1:0] vs_wd, vsel;
  logic [6:0] rd_addr;
  logic [15:0] rd_data;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;

  // ==========================================================================
  // Design and controller model
  pps_status u_dut (.clk(clk), .srst(srst), .fault_a_notify_pin(fa),
    .fault_b_notify_pin(fb), .enable_pin(en), .inverted_pwm_pin(ipwm),
    .pwm_input_pin(pwm), .ref_window_pin(win), .last_frame_rejected(lfr),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_unmapped(rd_unmapped), .verification_select_we(vs_we),
    .verification_select_wdata(vs_wd), .clear_primary_bit(clr),
    .self_test_entry(ste), .default_mode_entry(dme), .verification_select(vsel),
    .check_active(act), .check_done(done));

  pps_host u_host (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_unmapped(rd_unmapped));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      results();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Odd parity over the whole word
  function automatic logic [15:0] word(logic [15:2] body);
    return {body, lfr, ~^{body, lfr}};
  endfunction : word

  task automatic rd_chk(logic [6:0] a, logic [15:0] exp, logic um_exp);
    logic [15:0] d;
    logic um, v;
    u_host.read(a, d, um, v);
    check("rd_valid", {15'h0, v}, 16'h0001);
    check("rd_unmapped", {15'h0, um}, {15'h0, um_exp});
    check("rd_data", d, exp);
  endtask : rd_chk

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    check("rd_data_rst", rd_data, PPS_CLK_CHECK_RESET);
    check("ctl_rst", {12'h0, vsel, act, done}, 16'h0000);
    rd_chk(PPS_ADDR_CLK_CHECK, PPS_CLK_CHECK_RESET, 1'b0);
  endtask : t_reset

  task automatic t_pins();
    logic [4:0] v;
    for (int i = 0; i < 6; i++) begin
      v = (i == 5) ? 5'h1F : (5'h10 >> i);
      @(negedge clk);
      {fb, fa, en, ipwm, pwm} = v;
      lfr = i[0];
      repeat (4) @(negedge clk);
      rd_chk(PPS_ADDR_PIN_LEVELS, word({9'h000, v}),
        1'b0);
    end
  endtask : t_pins

  task automatic t_unmapped();
    rd_chk(7'h0C, word(14'h0000), 1'b1);
    rd_chk(7'h7F, word(14'h0000), 1'b1);
  endtask : t_unmapped

  task automatic t_refuse();
    @(negedge clk);
    vs_we = 1'b1;
    vs_wd = PPS_VSEL_CLK_CHECK;
    @(negedge clk);
    vs_we = 1'b0;
    dme = 1'b1;
    @(negedge clk);
    dme = 1'b0;
    check("vsel_cleared", {14'h0, vsel}, 16'h0000);
    ste = 1'b1;
    @(negedge clk);
    ste = 1'b0;
    @(negedge clk);
    check("no_check", {15'h0, act}, 16'h0000);
  endtask : t_refuse

  task automatic t_measure(int n, logic [7:0] cnt);
    int k;
    @(negedge clk);
    vs_we = 1'b1;
    vs_wd = PPS_VSEL_CLK_CHECK;
    @(negedge clk);
    vs_we = 1'b0;
    check("armed_idle", {12'h0, vsel, act, done}, 16'h0008);
    ste = 1'b1;
    @(negedge clk);
    ste = 1'b0;
    check("active", {15'h0, act}, 16'h0001);
    win = 1'b1;
    repeat (n) @(negedge clk);
    win = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    // Active still high with the done pulse, drops one cycle later
    check("done", {14'h0, done, act}, 16'h0003);
    @(negedge clk);
    check("ended", {14'h0, done, act}, 16'h0000);
    rd_chk(PPS_ADDR_CLK_CHECK, word({cnt, 6'h00}), 1'b0);
    @(negedge clk);
    dme = 1'b1;
    @(negedge clk);
    dme = 1'b0;
    check("vsel_dflt", {14'h0, vsel}, 16'h0000);
  endtask : t_measure

  task automatic t_clear();
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    rd_chk(PPS_ADDR_CLK_CHECK, word(14'h0000), 1'b0);
  endtask : t_clear

  // ==========================================================================
  // Main sequence
  initial begin
    {srst, fa, fb, en, ipwm, pwm, win, lfr} = 8'h80;
    {vs_we, clr, ste, dme} = 4'h0;
    vs_wd = PPS_VSEL_DISABLED;
    repeat (12) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_pins();
    t_unmapped();
    t_refuse();
    // Edge that sees the window open is not counted
    t_measure(37, 8'h24);
    t_clear();
    t_measure(300, PPS_CNT_MAX);
    t_clear();
    results();
  end
endmodule : tb_top
